// >>> pkg/eiv_pkg.sv
// Function
// RQ1: Pin events are detected only while the pin function enable bit is 1.
// RQ2: Enabled pin is sampled by clocked logic for edge or edge-and-level events.
// RQ3: In stop mode an enabled pin wakes the device through a clockless path.
// RQ4: Software selects polarity, edge or edge-and-level mode, and interrupt or polling.
// RQ5: Polarity 1 means rising or high; polarity 0 means falling or low.
// RQ6: With the pin enabled, the pull device is on by default, following polarity.
// RQ7: Writing 1 to the pull disable bit turns the internal pull device off.
// RQ8: The event flag sets when the pin goes from deasserted to asserted level.
// RQ9: In edge-and-level mode the flag stays set while the pin stays asserted.
// RQ10: Writing 1 to acknowledge clears the flag; 0 does nothing; it reads 0.
// RQ11: The synchronised pin level is presented for branch-on-pin-level tests.
// RQ12: Each source has its own flag; it requests only when locally enabled.
// RQ13: Maskable requests reach the core only while the global mask is 0.
// RQ14: Among pending sources the lowest vector number wins.
// RQ15: Vector n holds its high byte at 0xFFFE minus 2n, low byte above.
// RQ16: Pin uses vector 2 gated by its enable; software trap uses vector 1.
// RQ17: All reset causes share vector 0; vectors 8, 13 and 14 are reserved.
// RQ18: Vectors 30 and 31 belong to no source.
// RQ19: Pin passes two synchroniser stages; the wake path never sets the flag.
package eiv_pkg;
    localparam int EIV_ADDR_W = 8;
    localparam int EIV_DATA_W = 32;
    localparam int EIV_NVEC = 32;
    localparam int EIV_NEVT = 2;
    localparam int EIV_NRST = 8;
    // Register offsets
    localparam logic [7:0] EIV_OFF_CTRL = 8'h00;
    localparam logic [7:0] EIV_OFF_LEVEL = 8'h04;
    localparam logic [7:0] EIV_OFF_VECTOR = 8'h08;
    localparam logic [7:0] EIV_OFF_EVT = 8'h0C;
    localparam logic [7:0] EIV_OFF_EVT_MASK = 8'h10;
    // Status and control field positions
    localparam int EIV_B_MODE = 0;
    localparam int EIV_B_IE = 1;
    localparam int EIV_B_ACK = 2;
    localparam int EIV_B_FLAG = 3;
    localparam int EIV_B_PE = 4;
    localparam int EIV_B_POL = 5;
    localparam int EIV_B_PDD = 6;
    localparam logic [7:0] EIV_CTRL_WMASK = 8'h73;
    // Event status positions
    localparam int EIV_E_PIN = 0;
    localparam int EIV_E_REQ = 1;
    // Reset values
    localparam logic [7:0] EIV_CTRL_RST = 8'h00;
    localparam logic [1:0] EIV_EVT_RST = 2'h0;
    localparam logic [1:0] EIV_MASK_RST = 2'h0;
    // Vector map
    localparam logic [4:0] EIV_VEC_RESET = 5'h00;
    localparam logic [4:0] EIV_VEC_TRAP = 5'h01;
    localparam logic [4:0] EIV_VEC_PIN = 5'h02;
    localparam logic [15:0] EIV_VEC_TOP = 16'hFFFE;
    localparam logic [31:0] EIV_VEC_UNASSIGNED = 32'hC000_6100;
    localparam logic [31:0] EIV_VEC_INTERNAL = 32'h0000_0007;
    // Bus responses
    localparam logic [1:0] EIV_RESP_OKAY = 2'h0;
    localparam logic [1:0] EIV_RESP_SLVERR = 2'h2;
endpackage

// >>> pkg/eiv_pin_if.sv
`timescale 1ns/1ps
interface eiv_pin_if;
    logic enable;
    logic polarity;
    logic level;
    logic asserted;
    logic edge_evt;
    modport det
    (
        input enable,
        input polarity,
        output level,
        output asserted,
        output edge_evt
    );
    modport ctl
    (
        output enable,
        output polarity,
        input level,
        input asserted,
        input edge_evt
    );
endinterface // eiv_pin_if

// >>> rtl/eiv_pin_detect.sv
`timescale 1ns/1ps
module eiv_pin_detect
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pin
    input wire logic ext_pin,
    // Detector results
    eiv_pin_if.det pin
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic asserted_now;

    // Two stages before any clocked logic looks at the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= ext_pin; // RQ19
            sync2_r <= sync1_r; // RQ19
        end
    end

    // Asserted level follows polarity, gated by pin enable
    assign asserted_now = pin.enable & (sync2_r == pin.polarity); // RQ1 RQ5

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_r <= 1'b0;
        else
            prev_r <= asserted_now; // RQ2
    end

    assign pin.level = sync2_r; // RQ11
    assign pin.asserted = asserted_now;
    assign pin.edge_evt = asserted_now & ~prev_r; // RQ2 RQ8
endmodule // eiv_pin_detect

// >>> rtl/eiv_top.sv
`timescale 1ns/1ps
module eiv_top
    import eiv_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [eiv_pkg::EIV_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [eiv_pkg::EIV_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [eiv_pkg::EIV_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [eiv_pkg::EIV_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External pin side
    input wire logic ext_pin,
    output logic pull_enable,
    output logic pull_up,
    input wire logic stop_mode,
    output logic wake,
    // Core side
    input wire logic ccr_mask,
    input wire logic software_trap,
    input wire logic [eiv_pkg::EIV_NRST-1:0] reset_cause,
    input wire logic [eiv_pkg::EIV_NVEC-1:0] src_flag,
    input wire logic [eiv_pkg::EIV_NVEC-1:0] src_enable,
    output logic cpu_request,
    output logic [4:0] vector_number,
    output logic [15:0] vector_address,
    output logic pin_level,
    // Interrupt
    output logic irq
);
    import eiv_pkg::*;

    // Register select, one-hot over the mapped words
    function automatic logic [4:0] eiv_reg_sel(input logic [EIV_ADDR_W-1:0] a);
        logic [7:0] w;
        w = {a[EIV_ADDR_W-1:2], 2'b00};
        eiv_reg_sel = {w == EIV_OFF_EVT_MASK, w == EIV_OFF_EVT, w == EIV_OFF_VECTOR,
                       w == EIV_OFF_LEVEL, w == EIV_OFF_CTRL};
    endfunction

    // Lowest set bit wins
    function automatic logic [4:0] eiv_first(input logic [EIV_NVEC-1:0] v);
        eiv_first = EIV_VEC_RESET;
        for (int i = EIV_NVEC - 1; i >= 0; i--)
        begin
            if (v[i])
                eiv_first = 5'(i);
        end
    endfunction

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [EIV_DATA_W-1:0] rdata_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [EIV_ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [7:0] ctrl_r;
    logic flag_r;
    logic [EIV_NEVT-1:0] evt_r;
    logic [EIV_NEVT-1:0] mask_r;
    logic irq_r;
    logic cpu_req_r;
    logic [4:0] vec_num_r;
    logic [15:0] vec_addr_r;
    logic pin_level_r;
    logic pull_en_r;
    logic pull_up_r;

    // Bus handshakes
    wire aw_take = s_axi_awvalid & awready_r;
    wire w_take = s_axi_wvalid & wready_r;
    wire ar_take = s_axi_arvalid & arready_r;
    wire wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
    wire bvalid_nxt = wr_go | (bvalid_r & ~s_axi_bready);
    wire aw_hold_nxt = (aw_hold_r & ~wr_go) | aw_take;
    wire w_hold_nxt = (w_hold_r & ~wr_go) | w_take;
    wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

    // Address decode
    wire [4:0] wsel = eiv_reg_sel(awaddr_r);
    wire [4:0] rsel = eiv_reg_sel(s_axi_araddr);
    wire wr_en = wr_go & wstrb0_r;
    wire wr_ctrl = wr_en & wsel[0];
    wire wr_mask = wr_en & wsel[4];
    wire rd_evt = ar_take & rsel[3];

    // Pin detector
    eiv_pin_if pin_bus ();
    assign pin_bus.enable = ctrl_r[EIV_B_PE]; // RQ1 RQ4
    assign pin_bus.polarity = ctrl_r[EIV_B_POL]; // RQ4 RQ5

    eiv_pin_detect u_detect
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_pin(ext_pin),
        .pin(pin_bus)
    );

    // Pin event flag, set beats acknowledge
    wire ack_clr = wr_ctrl & wdata_r[EIV_B_ACK]; // RQ10
    wire flag_set = pin_bus.edge_evt | (ctrl_r[EIV_B_MODE] & pin_bus.asserted); // RQ8 RQ9
    wire flag_nxt = flag_set | (flag_r & ~ack_clr); // RQ9 RQ10
    wire [7:0] ctrl_nxt = wr_ctrl ? (wdata_r & EIV_CTRL_WMASK) : ctrl_r; // RQ4 RQ7

    // Vector selection
    wire pin_req = flag_r & ctrl_r[EIV_B_IE]; // RQ12 RQ16
    wire [EIV_NVEC-1:0] src_gated = src_flag & src_enable & ~EIV_VEC_UNASSIGNED & ~EIV_VEC_INTERNAL; // RQ12 RQ17 RQ18
    wire [EIV_NVEC-1:0] pending = src_gated | {29'h0, pin_req, software_trap, |reset_cause}; // RQ16 RQ17
    wire [4:0] vec_num_nxt = eiv_first(pending); // RQ14
    wire [15:0] vec_addr_nxt = EIV_VEC_TOP - {10'h0, vec_num_nxt, 1'b0}; // RQ15
    wire maskable = |pending[EIV_NVEC-1:2];
    wire cpu_req_nxt = pending[0] | pending[1] | (maskable & ~ccr_mask); // RQ13

    // Event status, set beats the clearing read
    wire [EIV_NEVT-1:0] evt_set = {cpu_req_nxt & ~cpu_req_r, flag_nxt & ~flag_r};
    wire [EIV_NEVT-1:0] evt_nxt = evt_set | (evt_r & {EIV_NEVT{~rd_evt}});
    wire [EIV_NEVT-1:0] mask_nxt = wr_mask ? wdata_r[EIV_NEVT-1:0] : mask_r;

    // Read data
    wire [EIV_DATA_W-1:0] rd_ctrl = {24'h0, ctrl_r} | (32'(flag_r) << EIV_B_FLAG); // RQ10
    wire [EIV_DATA_W-1:0] rd_level = {31'h0, pin_level_r};
    wire [EIV_DATA_W-1:0] rd_vec = {10'h0, cpu_req_r, vec_num_r, vec_addr_r};
    wire [EIV_DATA_W-1:0] rd_evt_w = {30'h0, evt_r};
    wire [EIV_DATA_W-1:0] rd_mask_w = {30'h0, mask_r};
    wire [EIV_DATA_W-1:0] rd_mux = ({32{rsel[0]}} & rd_ctrl) | ({32{rsel[1]}} & rd_level)
                                 | ({32{rsel[2]}} & rd_vec) | ({32{rsel[3]}} & rd_evt_w)
                                 | ({32{rsel[4]}} & rd_mask_w);

    // Clockless wake path, never touches the flag
    assign wake = stop_mode & ctrl_r[EIV_B_PE] & (ext_pin == ctrl_r[EIV_B_POL]); // RQ3 RQ19

    // Write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= EIV_RESP_OKAY;
        end
        else
        begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
            wready_r <= ~w_hold_nxt & ~bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (wr_go)
                bresp_r <= (|wsel) ? EIV_RESP_OKAY : EIV_RESP_SLVERR;
        end
    end

    // Write payload capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end
        else
        begin
            if (aw_take)
                awaddr_r <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= EIV_RESP_OKAY;
            rdata_r <= '0;
        end
        else
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= rd_mux;
                rresp_r <= (|rsel) ? EIV_RESP_OKAY : EIV_RESP_SLVERR;
            end
        end
    end

    // Control, flag and interrupt state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= EIV_CTRL_RST;
            flag_r <= 1'b0;
            evt_r <= EIV_EVT_RST;
            mask_r <= EIV_MASK_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt; // RQ8 RQ12
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(evt_nxt & mask_nxt);
        end
    end

    // Core-facing and pin-facing outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_req_r <= 1'b0;
            vec_num_r <= EIV_VEC_RESET;
            vec_addr_r <= EIV_VEC_TOP;
            pin_level_r <= 1'b0;
            pull_en_r <= 1'b0;
            pull_up_r <= 1'b1;
        end
        else
        begin
            cpu_req_r <= cpu_req_nxt; // RQ13
            vec_num_r <= vec_num_nxt; // RQ14
            vec_addr_r <= vec_addr_nxt; // RQ15
            pin_level_r <= pin_bus.level & ctrl_r[EIV_B_PE]; // RQ11
            pull_en_r <= ctrl_r[EIV_B_PE] & ~ctrl_r[EIV_B_PDD]; // RQ6 RQ7
            pull_up_r <= ~ctrl_r[EIV_B_POL]; // RQ6
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign irq = irq_r;
    assign cpu_request = cpu_req_r;
    assign vector_number = vec_num_r;
    assign vector_address = vec_addr_r;
    assign pin_level = pin_level_r;
    assign pull_enable = pull_en_r;
    assign pull_up = pull_up_r;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_disabled_quiet;
        !ctrl_r[EIV_B_PE] && !flag_r |=> !flag_r;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while pin disabled"); // RQ1

    property p_edge_sets;
        pin_bus.edge_evt |=> flag_r;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag"); // RQ8

    property p_level_holds;
        ctrl_r[EIV_B_MODE] && pin_bus.asserted |=> flag_r;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level mode flag dropped"); // RQ9

    property p_ack_clears;
        flag_r && ack_clr && !flag_set |=> !flag_r;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("acknowledge did not clear flag"); // RQ10

    property p_pull_off;
        wr_ctrl && wdata_r[EIV_B_PDD] |-> ##2 !pull_en_r;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull device still on"); // RQ7

    property p_vec_addr;
        vec_addr_r == 16'(EIV_VEC_TOP - {10'h0, vec_num_r, 1'b0});
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address mismatch"); // RQ15

    property p_pin_vector;
        pin_req && !(|reset_cause) && !software_trap |=> vec_num_r == EIV_VEC_PIN && cpu_req_r == !$past(ccr_mask);
    endproperty
    a_pin_vector: assert property (p_pin_vector) else $error("pin vector not chosen"); // RQ14 RQ16

    property p_masked;
        ccr_mask && !pending[0] && !pending[1] |=> !cpu_req_r;
    endproperty
    a_masked: assert property (p_masked) else $error("request passed global mask"); // RQ13

    property p_unassigned;
        cpu_req_r |-> !EIV_VEC_UNASSIGNED[vec_num_r];
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned vector requested"); // RQ17 RQ18

    property p_sync_delay;
        ##2 pin_bus.level == $past(ext_pin, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("pin synchroniser depth wrong"); // RQ2 RQ19

    c_flag_set: cover property (!flag_r ##1 flag_r);
    c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
    c_read_resp: cover property (s_axi_rvalid && s_axi_rready && rdata_r[EIV_B_FLAG]);
    c_pin_request: cover property (cpu_req_r && vec_num_r == EIV_VEC_PIN);
endmodule // eiv_top

// >>> testbench/eiv_pin_src.sv
`timescale 1ns/1ps
module eiv_pin_src
(
    // Clock
    input wire logic aclk,
    // Bench control
    input wire logic drive_en,
    input wire logic drive_val,
    // Pull device
    input wire logic pull_enable,
    input wire logic pull_up,
    // Pin
    output logic ext_pin
);
    logic idle_r = 1'b0;
    // Floating pin wanders every cycle
    always_ff @(posedge aclk)
    begin
        idle_r <= ~idle_r;
    end
    // Released pin follows the pull device
    assign ext_pin = drive_en ? drive_val : (pull_enable ? pull_up : idle_r);
endmodule // eiv_pin_src

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import eiv_pkg::*;
    typedef struct packed {
        logic [31:0] flg;
        logic [31:0] en;
        logic [7:0] rst;
        logic trap;
        logic msk;
        logic [4:0] vn;
        logic req;
    } eiv_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ext_pin, pull_enable, pull_up, wake, cpu_request, pin_level, irq;
    logic pin_drv = 1'b1, pin_val = 1'b0, stop_mode = 1'b0, ccr_mask = 1'b0, software_trap = 1'b0;
    logic [7:0] reset_cause = 8'h00;
    logic [31:0] src_flag = 32'h0, src_enable = 32'h0;
    logic [4:0] vector_number;
    logic [15:0] vector_address;
    logic [31:0] rdat;
    logic [1:0] resp;
    int miscompares = 0;
    int checked = 0;
    eiv_row_t rows [10] = '{
        '{32'h0000_0000, 32'h0000_0000, 8'h00, 1'b0, 1'b0, 5'h00, 1'b0},
        '{32'h2000_0008, 32'hFFFF_FFFF, 8'h00, 1'b0, 1'b0, 5'h03, 1'b1},
        '{32'h2000_0000, 32'h2000_0000, 8'h00, 1'b0, 1'b0, 5'h1D, 1'b1},
        '{32'h2000_0000, 32'h0000_0000, 8'h00, 1'b0, 1'b0, 5'h00, 1'b0},
        '{32'h2000_0000, 32'hFFFF_FFFF, 8'h00, 1'b0, 1'b1, 5'h1D, 1'b0},
        '{32'h0000_0008, 32'hFFFF_FFFF, 8'h00, 1'b1, 1'b1, 5'h01, 1'b1},
        '{32'h0000_0000, 32'h0000_0000, 8'h80, 1'b1, 1'b0, 5'h00, 1'b1},
        '{32'hC000_6100, 32'hFFFF_FFFF, 8'h00, 1'b0, 1'b0, 5'h00, 1'b0},
        '{32'h0000_0300, 32'hFFFF_FFFF, 8'h00, 1'b0, 1'b0, 5'h09, 1'b1},
        '{32'h0000_0004, 32'hFFFF_FFFF, 8'h00, 1'b0, 1'b0, 5'h00, 1'b0}
    };

    always #5 aclk = ~aclk;

    eiv_pin_src eiv_pin_src_i (.aclk(aclk), .drive_en(pin_drv), .drive_val(pin_val),
        .pull_enable(pull_enable), .pull_up(pull_up), .ext_pin(ext_pin));

    eiv_top eiv_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_pin(ext_pin),
        .pull_enable(pull_enable), .pull_up(pull_up), .stop_mode(stop_mode), .wake(wake),
        .ccr_mask(ccr_mask), .software_trap(software_trap), .reset_cause(reset_cause),
        .src_flag(src_flag), .src_enable(src_enable), .cpu_request(cpu_request),
        .vector_number(vector_number), .vector_address(vector_address), .pin_level(pin_level), .irq(irq));

    task automatic close_out();
        begin
            $display("Comparisons %0d, mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
            begin
                $display("All tests passed");
            end
            else
            begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task automatic tmo(input string nm);
        begin
            miscompares++;
            $display("MISMATCH %s expected answer seen timeout", nm);
            close_out();
        end
    endtask

    task automatic tick(input int n);
        begin
            repeat (n) @(posedge aclk);
            #1;
        end
    endtask

    task automatic pin(input logic v, input int n);
        begin
            @(posedge aclk);
            pin_val <= v;
            tick(n);
        end
    endtask

    // Write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic ad = 1'b0;
        logic dd = 1'b0;
        logic got = 1'b0;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!got && n < 40)
            begin
                @(posedge aclk);
                n++;
                if (!ad && s_axi_awready)
                begin
                    ad = 1'b1;
                    s_axi_awvalid <= 1'b0;
                end
                if (!dd && s_axi_wready)
                begin
                    dd = 1'b1;
                    s_axi_wvalid <= 1'b0;
                end
                if (s_axi_bvalid)
                begin
                    got = 1'b1;
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                end
            end
            if (!got)
            begin
                tmo("write");
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        int n = 0;
        logic ta = 1'b0;
        logic got = 1'b0;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!got && n < 40)
            begin
                @(posedge aclk);
                n++;
                if (!ta && s_axi_arready)
                begin
                    ta = 1'b1;
                    s_axi_arvalid <= 1'b0;
                end
                if (s_axi_rvalid)
                begin
                    got = 1'b1;
                    rdat = s_axi_rdata;
                    resp = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                end
            end
            if (!got)
            begin
                tmo("read");
            end
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        begin
            rd(a);
            chk($sformatf("read %h", a), rdat, e);
        end
    endtask

    initial
    begin
        tick(16);
        chk("irq", 32'(irq), 32'h0);
        chk("vector_address", 32'(vector_address), 32'h0000_FFFE);
        chk("pull", 32'({pull_enable, pull_up, pin_level, wake}), 32'h4);
        @(posedge aclk);
        aresetn <= 1'b1;
        rdc(EIV_OFF_CTRL, 32'h0);
        rdc(EIV_OFF_EVT_MASK, 32'h0);
        // Priority table
        foreach (rows[i])
        begin
            @(posedge aclk);
            src_flag <= rows[i].flg;
            src_enable <= rows[i].en;
            reset_cause <= rows[i].rst;
            software_trap <= rows[i].trap;
            ccr_mask <= rows[i].msk;
            tick(3);
            chk("vector_number", 32'(vector_number), 32'(rows[i].vn));
            chk("cpu_request", 32'(cpu_request), 32'(rows[i].req));
            chk("vector_address", 32'(vector_address), 32'(16'hFFFE - {10'h0, rows[i].vn, 1'b0}));
        end
        @(posedge aclk);
        src_flag <= 32'h0;
        reset_cause <= 8'h00;
        software_trap <= 1'b0;
        ccr_mask <= 1'b0;
        // Rising edge mode with interrupt
        wr(EIV_OFF_EVT_MASK, 32'h1);
        wr(EIV_OFF_CTRL, 32'h32);
        tick(2);
        chk("pull", 32'({pull_enable, pull_up}), 32'h2);
        rdc(EIV_OFF_CTRL, 32'h32);
        rd(EIV_OFF_EVT);
        pin(1'b1, 6);
        chk("pin_level", 32'(pin_level), 32'h1);
        chk("vector", 32'({cpu_request, vector_number, vector_address}), 32'h0022_FFFA);
        chk("irq", 32'(irq), 32'h1);
        rdc(EIV_OFF_VECTOR, 32'h0022_FFFA);
        rdc(EIV_OFF_LEVEL, 32'h1);
        rdc(EIV_OFF_CTRL, 32'h3A);
        rdc(EIV_OFF_EVT, 32'h3);
        tick(2);
        chk("irq", 32'(irq), 32'h0);
        wr(EIV_OFF_CTRL, 32'h36);
        rdc(EIV_OFF_CTRL, 32'h32);
        tick(2);
        chk("cpu_request", 32'(cpu_request), 32'h0);
        pin(1'b0, 3);
        pin(1'b1, 6);
        wr(EIV_OFF_CTRL, 32'h32);
        rdc(EIV_OFF_CTRL, 32'h3A);
        wr(EIV_OFF_CTRL, 32'h30);
        tick(3);
        chk("cpu_request", 32'(cpu_request), 32'h0);
        rdc(EIV_OFF_CTRL, 32'h38);
        // Edge and level mode
        wr(EIV_OFF_CTRL, 32'h37);
        rdc(EIV_OFF_CTRL, 32'h3B);
        wr(EIV_OFF_CTRL, 32'h37);
        rdc(EIV_OFF_CTRL, 32'h3B);
        pin(1'b0, 4);
        wr(EIV_OFF_CTRL, 32'h37);
        rdc(EIV_OFF_CTRL, 32'h33);
        // Wake from stop
        @(posedge aclk);
        stop_mode <= 1'b1;
        pin(1'b1, 2);
        chk("wake", 32'(wake), 32'h1);
        pin(1'b0, 1);
        chk("wake", 32'(wake), 32'h0);
        @(posedge aclk);
        stop_mode <= 1'b0;
        // Falling polarity, event masked then unmasked
        wr(EIV_OFF_EVT_MASK, 32'h0);
        pin(1'b1, 4);
        wr(EIV_OFF_CTRL, 32'h10);
        wr(EIV_OFF_CTRL, 32'h14);
        rd(EIV_OFF_EVT);
        rdc(EIV_OFF_CTRL, 32'h10);
        chk("pull", 32'({pull_enable, pull_up}), 32'h3);
        pin(1'b0, 6);
        rdc(EIV_OFF_CTRL, 32'h18);
        chk("irq", 32'(irq), 32'h0);
        wr(EIV_OFF_EVT_MASK, 32'h1);
        tick(2);
        chk("irq", 32'(irq), 32'h1);
        rdc(EIV_OFF_EVT, 32'h1);
        tick(2);
        chk("irq", 32'(irq), 32'h0);
        // Pull disable and released pin
        wr(EIV_OFF_CTRL, 32'h50);
        tick(2);
        chk("pull_enable", 32'(pull_enable), 32'h0);
        wr(EIV_OFF_CTRL, 32'h10);
        @(posedge aclk);
        pin_drv <= 1'b0;
        tick(4);
        chk("pin_level", 32'(pin_level), 32'h1);
        @(posedge aclk);
        pin_val <= 1'b1;
        pin_drv <= 1'b1;
        // Disabled pin ignores activity
        wr(EIV_OFF_CTRL, 32'h04);
        pin(1'b0, 6);
        rdc(EIV_OFF_CTRL, 32'h0);
        chk("pin_level", 32'({pin_level, pull_enable}), 32'h0);
        // Unmapped word
        wr(8'h20, 32'hFF);
        chk("bresp", 32'(resp), 32'(EIV_RESP_SLVERR));
        rdc(8'h20, 32'h0);
        chk("rresp", 32'(resp), 32'(EIV_RESP_SLVERR));
        close_out();
    end
endmodule // tb
